// File: hdl/adcs_seq.sv
// Overview of operation
// - each result is ten bits or eight bits, chosen by software.
// - software chooses which of eight analog channels is converted.
// - one-shot converts one channel or a run, then halts.
// - continuous repeats the single channel or run without further activation.
// - stop mode converts one channel, then waits for the next activation.
// - each completed conversion raises an interrupt and starts the I/O service.
// - with interrupts enabled, a pending result is never overwritten.
// - start comes from software, timer 1 rising edge, or trigger falling edge.
// - a full conversion with sampling takes at least 6.13 us.
// - sample-and-hold lasts at least 3.75 us.
module adcs_seq (
    // clock and reset
    input  wire logic                        MCLK_I,
    input  wire logic                        RST_N_I,
    // configuration
    input  wire logic [1:0]                  MODE_I,
    input  wire logic                        RES8_I,
    input  wire logic [adcs_pkg::CH_W-1:0]   START_CH_I,
    input  wire logic [adcs_pkg::CH_W-1:0]   END_CH_I,
    input  wire logic [1:0]                  TRG_SEL_I,
    input  wire logic                        INT_EN_I,
    // control
    input  wire logic                        SW_START_I,
    input  wire logic                        ABORT_I,
    input  wire logic                        IRQ_CLR_I,
    // start pins
    input  wire logic                        TIM1_I,
    input  wire logic                        EXT_TRG_I,
    // analog front end
    input  wire logic                        CMP_I,
    output logic                             SH_O,
    output logic [adcs_pkg::CH_W-1:0]        ANA_CH_O,
    output logic [adcs_pkg::RES_W-1:0]       DAC_CODE_O,
    // results and status
    output logic [adcs_pkg::RES_W-1:0]       RESULT_O,
    output logic [adcs_pkg::CH_W-1:0]        RESULT_CH_O,
    output logic                             IRQ_O,
    output logic                             IOS_REQ_O,
    output logic                             BUSY_O
);

    typedef enum logic [4:0] {
        S_IDLE   = 5'h01,
        S_SAMPLE = 5'h02,
        S_CONV   = 5'h04,
        S_STORE  = 5'h08,
        S_PAUSE  = 5'h10
    } adcs_state_t;

    adcs_state_t                     state_q, state_d;
    adcs_pkg::adcs_cfg_t             cfg;
    adcs_pkg::adcs_res_t             res_q, res_d;
    logic [adcs_pkg::CNT_W-1:0]      cnt_q, cnt_d;
    logic [adcs_pkg::CH_W-1:0]       ch_q, ch_d;
    logic [adcs_pkg::RES_W-1:0]      dac_q, dac_d;
    logic [3:0]                      bit_q, bit_d;
    logic                            irq_q, irq_d;
    logic                            ios_q, ios_d;
    logic                            cmp_meta_q, cmp_q;
    logic                            start_p;
    logic                            cnt_done;
    logic                            last_bit;
    logic                            last_ch;
    logic                            can_store;
    logic [adcs_pkg::CH_W-1:0]       next_ch;
    logic [3:0]                      lsb_idx;

    localparam logic [adcs_pkg::CNT_W-1:0] SAMP_LD =
        adcs_pkg::CNT_W'(adcs_pkg::SAMP_CYC - 1);
    localparam logic [adcs_pkg::CNT_W-1:0] BIT_LD =
        adcs_pkg::CNT_W'(adcs_pkg::BIT_CYC - 1);

    // one-hot mask of a bit position in the trial code
    function automatic logic [adcs_pkg::RES_W-1:0] bit_mask(input logic [3:0] idx);
        bit_mask = adcs_pkg::RES_W'(10'h001 << idx);
    endfunction : bit_mask

    assign cfg = '{mode: MODE_I, res8: RES8_I, start_ch: START_CH_I,
                   end_ch: END_CH_I, trg_sel: TRG_SEL_I};

    adcs_trig u_trig (
        .clk_i      (MCLK_I),
        .rst_n_i    (RST_N_I),
        .sel_i      (cfg.trg_sel),
        .sw_start_i (SW_START_I),
        .tim1_i     (TIM1_I),
        .ext_trg_i  (EXT_TRG_I),
        .start_o    (start_p)
    );

    // comparator is asynchronous to the machine clock
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cmp_meta_q <= 1'b0;
            cmp_q      <= 1'b0;
        end else begin
            cmp_meta_q <= CMP_I;
            cmp_q      <= cmp_meta_q;
        end
    end

    // sequence decode
    assign cnt_done  = (cnt_q == '0);
    assign lsb_idx   = cfg.res8 ? adcs_pkg::LSB8_IDX : adcs_pkg::LSB10_IDX;
    assign last_bit  = (bit_q == lsb_idx);
    assign last_ch   = (ch_q == cfg.end_ch);
    assign next_ch   = last_ch ? cfg.start_ch : ch_q + 3'h1;
    // a pending result blocks the next store only while interrupts are enabled
    assign can_store = ~(INT_EN_I & irq_q);

    // sequencer next state
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        ch_d    = ch_q;
        dac_d   = dac_q;
        bit_d   = bit_q;
        res_d   = res_q;
        ios_d   = 1'b0;
        irq_d   = irq_q & ~IRQ_CLR_I;
        unique case (state_q)
            S_IDLE: begin
                if (start_p) begin
                    state_d = S_SAMPLE;
                    ch_d    = cfg.start_ch;
                    cnt_d   = SAMP_LD;
                end
            end
            S_PAUSE: begin
                if (start_p) begin
                    state_d = S_SAMPLE;
                    cnt_d   = SAMP_LD;
                end
            end
            S_SAMPLE: begin
                cnt_d = cnt_q - 11'h001;
                if (cnt_done) begin
                    state_d = S_CONV;
                    cnt_d   = BIT_LD;
                    bit_d   = adcs_pkg::MSB_IDX;
                    dac_d   = bit_mask(adcs_pkg::MSB_IDX);
                end
            end
            S_CONV: begin
                cnt_d = cnt_q - 11'h001;
                if (cnt_done) begin
                    // comparator low means the trial code is above the input
                    dac_d = cmp_q ? dac_q : (dac_q & ~bit_mask(bit_q));
                    cnt_d = BIT_LD;
                    if (last_bit) begin
                        state_d = S_STORE;
                    end else begin
                        bit_d = bit_q - 4'h1;
                        dac_d = dac_d | bit_mask(bit_q - 4'h1);
                    end
                end
            end
            S_STORE: begin
                if (can_store) begin
                    res_d.ch   = ch_q;
                    res_d.data = cfg.res8 ? {2'h0, dac_q[9:2]} : dac_q;
                    irq_d      = 1'b1;
                    ios_d      = 1'b1;
                    ch_d       = next_ch;
                    cnt_d      = SAMP_LD;
                    if (cfg.mode == adcs_pkg::ADCS_CONT) begin
                        state_d = S_SAMPLE;
                    end else if (last_ch) begin
                        state_d = S_IDLE;
                    end else if (cfg.mode == adcs_pkg::ADCS_STOP) begin
                        state_d = S_PAUSE;
                    end else begin
                        state_d = S_SAMPLE;
                    end
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
        if (ABORT_I) begin
            state_d = S_IDLE;
        end
    end

    // state registers
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_q <= S_IDLE;
            cnt_q   <= '0;
            ch_q    <= adcs_pkg::CH_RST;
            dac_q   <= adcs_pkg::RES_RST;
            bit_q   <= adcs_pkg::MSB_IDX;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            ch_q    <= ch_d;
            dac_q   <= dac_d;
            bit_q   <= bit_d;
        end
    end

    // result and event registers
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            res_q <= '{ch: adcs_pkg::CH_RST, data: adcs_pkg::RES_RST};
            irq_q <= 1'b0;
            ios_q <= 1'b0;
        end else begin
            res_q <= res_d;
            irq_q <= irq_d;   // set wins over a clear in the same cycle
            ios_q <= ios_d;
        end
    end

    // outputs
    assign SH_O        = (state_q == S_SAMPLE);
    assign ANA_CH_O    = ch_q;
    assign DAC_CODE_O  = dac_q;
    assign RESULT_O    = res_q.data;
    assign RESULT_CH_O = res_q.ch;
    assign IRQ_O       = irq_q;
    assign IOS_REQ_O   = ios_q;
    assign BUSY_O      = (state_q != S_IDLE);

endmodule : adcs_seq

// File: hdl/adcs_pkg.sv
package adcs_pkg;

    // channel, result and counter widths
    localparam int CH_W  = 3;
    localparam int RES_W = 10;
    localparam int CNT_W = 11;

    // timing: figures in ns, clock rate in MHz
    localparam int CLK_MHZ    = 250;
    localparam int T_SAMP_NS  = 3750;
    localparam int T_CONV_NS  = 6130;
    localparam int SAMP_CYC   = (T_SAMP_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV_CYC   = (T_CONV_NS * CLK_MHZ + 999) / 1000;
    // bit time is sized for 8 steps, so both resolutions meet the least conversion time
    localparam int RES8_STEPS = 8;
    localparam int BIT_CYC    = (CONV_CYC - SAMP_CYC + RES8_STEPS - 1) / RES8_STEPS;

    // bit positions of the successive approximation
    localparam logic [3:0] MSB_IDX    = 4'h9;
    localparam logic [3:0] LSB10_IDX  = 4'h0;
    localparam logic [3:0] LSB8_IDX   = 4'h2;

    // reset values
    localparam logic [RES_W-1:0] RES_RST = 10'h000;
    localparam logic [CH_W-1:0]  CH_RST  = 3'h0;
    // idle levels of the start pins, {ext trigger, timer 1}: sync chain starts here
    localparam logic [1:0]       PIN_RST = 2'h2;

    // conversion modes
    typedef enum logic [1:0] {
        ADCS_ONESHOT = 2'h0,
        ADCS_CONT    = 2'h1,
        ADCS_STOP    = 2'h2
    } adcs_mode_t;

    // start sources
    typedef enum logic [1:0] {
        ADCS_TRG_SW   = 2'h0,
        ADCS_TRG_TIM1 = 2'h1,
        ADCS_TRG_EXT  = 2'h2
    } adcs_trg_t;

    typedef struct packed {
        logic [1:0]      mode;
        logic            res8;
        logic [CH_W-1:0] start_ch;
        logic [CH_W-1:0] end_ch;
        logic [1:0]      trg_sel;
    } adcs_cfg_t;

    typedef struct packed {
        logic [CH_W-1:0]  ch;
        logic [RES_W-1:0] data;
    } adcs_res_t;

endpackage : adcs_pkg

// File: hdl/adcs_trig.sv
module adcs_trig (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // start sources
    input  wire logic [1:0] sel_i,
    input  wire logic       sw_start_i,
    input  wire logic       tim1_i,
    input  wire logic       ext_trg_i,
    // selected start event
    output logic            start_o
);

    logic [1:0] meta_q;
    logic [1:0] sync_q;
    logic [1:0] last_q;
    logic [1:0] raw;
    logic       tim1_rise;
    logic       ext_fall;

    assign raw = {ext_trg_i, tim1_i};

    // two flops per pin input, then a third for edge detection
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sync
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta_q[g] <= adcs_pkg::PIN_RST[g];
                    sync_q[g] <= adcs_pkg::PIN_RST[g];
                    last_q[g] <= adcs_pkg::PIN_RST[g];
                end else begin
                    meta_q[g] <= raw[g];
                    sync_q[g] <= meta_q[g];
                    last_q[g] <= sync_q[g];
                end
            end
        end
    endgenerate

    // whole chain resets to the pin's idle level, so release of reset is no edge
    assign tim1_rise = sync_q[0] & ~last_q[0];
    assign ext_fall  = ~sync_q[1] & last_q[1];

    // only the selected source starts a conversion
    assign start_o = (sel_i == adcs_pkg::ADCS_TRG_SW)   ? sw_start_i :
                     (sel_i == adcs_pkg::ADCS_TRG_TIM1) ? tim1_rise  :
                     (sel_i == adcs_pkg::ADCS_TRG_EXT)  ? ext_fall   :
                     1'b0;

endmodule : adcs_trig

// File: test/adcs_ana_model.sv
module adcs_ana_model (
    // channel and trial code from the sequencer
    input  wire logic [adcs_pkg::CH_W-1:0]    ch_i,
    input  wire logic [adcs_pkg::RES_W-1:0]   code_i,
    // ten-bit level of each of the eight inputs
    input  wire logic [8*adcs_pkg::RES_W-1:0] lvl_i,
    // comparator: high when input is at or above the code
    output logic                              cmp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ideal comparator, no offset, so results are exact levels
    assign cmp_o = lvl_i[ch_i*10 +: 10] >= code_i;
endmodule : adcs_ana_model

// File: test/adcs_seq_sva.sv
module adcs_seq_sva (
    input wire logic                        MCLK_I,
    input wire logic                        RST_N_I,
    input wire logic [1:0]                  MODE_I,
    input wire logic                        RES8_I,
    input wire logic [adcs_pkg::CH_W-1:0]   START_CH_I,
    input wire logic [adcs_pkg::CH_W-1:0]   END_CH_I,
    input wire logic [1:0]                  TRG_SEL_I,
    input wire logic                        INT_EN_I,
    input wire logic                        SW_START_I,
    input wire logic                        ABORT_I,
    input wire logic                        IRQ_CLR_I,
    input wire logic                        SH_O,
    input wire logic [adcs_pkg::CH_W-1:0]   ANA_CH_O,
    input wire logic [adcs_pkg::RES_W-1:0]  RESULT_O,
    input wire logic [adcs_pkg::CH_W-1:0]   RESULT_CH_O,
    input wire logic                        IRQ_O,
    input wire logic                        IOS_REQ_O,
    input wire logic                        BUSY_O
);
    timeunit 1ns;
    timeprecision 1ps;
    int sh_cnt_q;
    int conv_cnt_q;
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);
    // sampling length and time since sampling began
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sh_cnt_q   <= 0;
            conv_cnt_q <= 0;
        end else begin
            sh_cnt_q   <= SH_O ? sh_cnt_q + 1 : 0;
            conv_cnt_q <= (SH_O && sh_cnt_q == 0) ? 1 : conv_cnt_q + 1;
        end
    end
    a_start_taken: assert property (
        !BUSY_O && SW_START_I && TRG_SEL_I == 2'h0 && !ABORT_I
        |=> BUSY_O && SH_O && ANA_CH_O == $past(START_CH_I)) else $error("start not taken");
    a_sample_len: assert property (
        $fell(SH_O) && !$past(ABORT_I) |-> sh_cnt_q == adcs_pkg::SAMP_CYC)
        else $error("sampling length wrong");
    a_conv_time: assert property (
        IOS_REQ_O |-> conv_cnt_q >= adcs_pkg::CONV_CYC) else $error("conversion too short");
    a_store_irq: assert property (
        IOS_REQ_O |-> IRQ_O ##1 !IOS_REQ_O) else $error("store without irq or long pulse");
    a_irq_sticky: assert property (
        IRQ_O && !IRQ_CLR_I && !ABORT_I |=> IRQ_O) else $error("irq dropped");
    a_result_protect: assert property (
        INT_EN_I && IRQ_O && !IRQ_CLR_I |=> !IOS_REQ_O) else $error("pending result overwritten");
    a_result_hold: assert property (
        !IOS_REQ_O |-> $stable(RESULT_O) && $stable(RESULT_CH_O)) else $error("result moved");
    a_res8_field: assert property (
        IOS_REQ_O && RES8_I |-> RESULT_O[9:8] == 2'h0) else $error("8-bit result too wide");
    a_last_halt: assert property (
        IOS_REQ_O && MODE_I != 2'h1 && RESULT_CH_O == END_CH_I |-> !BUSY_O)
        else $error("no halt after last channel");
    a_stop_pause: assert property (
        IOS_REQ_O && MODE_I == 2'h2 && RESULT_CH_O != END_CH_I && !$past(ABORT_I)
        |-> BUSY_O && !SH_O)
        else $error("stop mode did not pause");
    a_cont_busy: assert property (
        IOS_REQ_O && MODE_I == 2'h1 && !$past(ABORT_I) |-> BUSY_O)
        else $error("continuous mode stopped");
    a_sh_busy: assert property (
        SH_O |-> BUSY_O) else $error("sampling while not busy");
    // main scenarios reached
    c_res8: cover property (IOS_REQ_O && RES8_I);
    c_pause: cover property (IOS_REQ_O && MODE_I == 2'h2 && BUSY_O);
    c_protect: cover property (INT_EN_I && IRQ_O && BUSY_O && !SH_O);
endmodule : adcs_seq_sva

// File: test/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, rst_n, res8, int_en, sw_start, abort, irq_clr, tim1, ext_trg;
    logic        cmp, sh, irq, ios, busy;
    logic [1:0]  mode, trg_sel;
    logic [2:0]  sch, ech, ana_ch, res_ch;
    logic [9:0]  dac, result;
    logic [79:0] lvl;
    int          seed = 32'h69875c6c;
    int          mismatches, cmp_count, cyc;
    adcs_seq i_dut (.MCLK_I(mclk), .RST_N_I(rst_n), .MODE_I(mode), .RES8_I(res8),
        .START_CH_I(sch), .END_CH_I(ech), .TRG_SEL_I(trg_sel), .INT_EN_I(int_en),
        .SW_START_I(sw_start), .ABORT_I(abort), .IRQ_CLR_I(irq_clr), .TIM1_I(tim1),
        .EXT_TRG_I(ext_trg), .CMP_I(cmp), .SH_O(sh), .ANA_CH_O(ana_ch), .DAC_CODE_O(dac),
        .RESULT_O(result), .RESULT_CH_O(res_ch), .IRQ_O(irq), .IOS_REQ_O(ios), .BUSY_O(busy));
    adcs_ana_model i_ana (.ch_i(ana_ch), .code_i(dac), .lvl_i(lvl), .cmp_o(cmp));
    // 250 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // hang guard, well above the longest expected run
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 90000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // ideal successive approximation: 8-bit keeps the top bits
    function automatic logic [9:0] exp_res(input logic [2:0] ch, input logic r8);
        logic [9:0] v;
        v = lvl[ch*10 +: 10];
        return r8 ? {2'h0, v[9:2]} : v;
    endfunction : exp_res
    // pins return to their idle level, which is not itself a start edge
    task fire(input logic [1:0] t);
        sw_start = (t == 2'h0);
        tim1     = (t == 2'h1);
        ext_trg  = (t != 2'h2);
        repeat (5) @(negedge mclk);
        sw_start = 1'b0;
        tim1     = 1'b0;
        ext_trg  = 1'b1;
    endtask : fire
    task automatic run(input logic [1:0] m, input logic r8, input logic [2:0] s,
                       input logic [2:0] e, input logic [1:0] t, input logic ie);
        int n;
        int w;
        int span;
        logic [2:0] ch;
        for (int i = 0; i < 8; i++) lvl[i*10 +: 10] = 10'($random(seed));
        lvl[9:0]   = 10'h3ff;
        lvl[79:70] = 10'h000;
        // continuous mode takes one extra result, wrapping back to the first channel
        span = int'(3'(e - s)) + 1;
        n = span + ((m == 2'h1) ? 1 : 0);
        mode = m; res8 = r8; sch = s; ech = e; trg_sel = t; int_en = ie;
        fire(t);
        for (int k = 0; k < n; k++) begin
            w = 0;
            while (ios !== 1'b1 && w < 3000) begin
                @(negedge mclk);
                w++;
            end
            ch = 3'(s + 3'(k % span));
            check("result", result, exp_res(ch, r8));
            check("channel", {7'h0, res_ch}, {7'h0, ch});
            if (ie) begin
                repeat (2000) @(negedge mclk);
                check("held", result, exp_res(ch, r8));
            end
            irq_clr = 1'b1;
            @(negedge mclk);
            irq_clr = 1'b0;
            if (m == 2'h2 && k < n - 1) begin
                repeat (20) @(negedge mclk);
                check("paused", {9'h0, sh}, 10'h0);
                fire(t);
            end
        end
        abort = (m == 2'h1);
        @(negedge mclk);
        abort = 1'b0;
        repeat (3) @(negedge mclk);
        check("idle", {9'h0, busy}, 10'h0);
        $display("test mode %0d source %0d done", m, t);
    endtask : run
    // main sequence
    initial begin
        rst_n = 1'b0; mode = 2'h0; res8 = 1'b0; sch = 3'h0; ech = 3'h0; trg_sel = 2'h0;
        int_en = 1'b0; sw_start = 1'b0; abort = 1'b0; irq_clr = 1'b0; tim1 = 1'b0;
        ext_trg = 1'b1; lvl = 80'h0;
        repeat (12) @(negedge mclk);
        check("reset result", result, 10'h0);
        rst_n = 1'b1;
        @(negedge mclk);
        run(2'h0, 1'b0, 3'h3, 3'h3, 2'h0, 1'b0);
        run(2'h0, 1'b1, 3'h6, 3'h1, 2'h1, 1'b0);
        run(2'h2, 1'b0, 3'h0, 3'h2, 2'h2, 1'b0);
        run(2'h1, 1'b1, 3'h7, 3'h0, 2'h0, 1'b1);
        run(2'h1, 1'b0, 3'h4, 3'h4, 2'h1, 1'b0);
        run(2'h0, 1'b0, 3'h0, 3'h7, 2'h0, 1'b0);
        for (int i = 0; i < 3; i++) begin
            sch = 3'($random(seed));
            run(2'h0, 1'($random(seed)), sch, sch, 2'(i), 1'b0);
        end
        report_and_stop();
    end
endmodule : tb
bind adcs_seq adcs_seq_sva i_sva (
    .MCLK_I      (MCLK_I),
    .RST_N_I     (RST_N_I),
    .MODE_I      (MODE_I),
    .RES8_I      (RES8_I),
    .START_CH_I  (START_CH_I),
    .END_CH_I    (END_CH_I),
    .TRG_SEL_I   (TRG_SEL_I),
    .INT_EN_I    (INT_EN_I),
    .SW_START_I  (SW_START_I),
    .ABORT_I     (ABORT_I),
    .IRQ_CLR_I   (IRQ_CLR_I),
    .SH_O        (SH_O),
    .ANA_CH_O    (ANA_CH_O),
    .RESULT_O    (RESULT_O),
    .RESULT_CH_O (RESULT_CH_O),
    .IRQ_O       (IRQ_O),
    .IOS_REQ_O   (IOS_REQ_O),
    .BUSY_O      (BUSY_O)
);
